//--- spi_irq_pkg.sv
/*
  Package for the serial interrupt flag and vector block: register word
  offsets, field positions, reset values and vector codes.
  Assumes a 32-bit Avalon-MM slave with byte addressing.
*/
package spi_irq_pkg;

  localparam logic [3:0]  ADDR_IRQ_ENABLE = 4'h0;  // serial_irq_enable
  localparam logic [3:0]  ADDR_IRQ_FLAGS  = 4'h4;  // serial_irq_flags
  localparam logic [3:0]  ADDR_IRQ_VECTOR = 4'h8;  // serial_irq_vector
  localparam logic [3:0]  ADDR_ERR_STATUS = 4'hc;  // receive error bits

  localparam int          BIT_RX = 0;
  localparam int          BIT_TX = 1;
  localparam int          BIT_OVERRUN = 5;
  localparam int          BIT_FRAMING = 6;

  localparam logic [1:0]  ENABLE_RESET = 2'h0;
  localparam logic        TX_FLAG_RESET = 1'b1;
  localparam logic        RX_FLAG_RESET = 1'b0;

  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_RX   = 16'h0002;
  localparam logic [15:0] VEC_TX   = 16'h0004;

endpackage

//--- spi_serial_irq_flags_vector.sv
/*
  Interrupt enable, flag and vector logic of a serial port in SPI mode,
  with an Avalon-MM register slave and one level interrupt output.
  Assumes the shift and buffer logic delivers one-cycle event pulses
  on the same clock: buffer written, buffer moved to shifter, character
  done, buffer read, overrun and framing error.
*/
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// - Transmit enable bit, zero after reset
// - Receive enable bit, zero after reset
// - Transmit flag set while holding buffer empty
// - Receive flag set on completed character
// - Vector reads zero when nothing enabled pending
// - Vector two for receive, highest priority
// - Vector four for transmit, lowest priority
// - Buffer write clears transmit flag until moved
// - Receive buffer read clears flag and errors
module spi_serial_irq_flags_vector (
  input  wire logic        clk,            // 20 MHz module clock
  input  wire logic        arst_n,         // Asynchronous reset, low
  input  wire logic [3:0]  address,        // Avalon byte address
  input  wire logic        read,           // Avalon read
  input  wire logic        write,          // Avalon write
  input  wire logic [31:0] writedata,      // Avalon write data
  input  wire logic [3:0]  byteenable,     // Avalon byte lanes
  output logic      [31:0] readdata,       // Avalon read data
  output logic             waitrequest,    // Avalon stall
  input  wire logic        tx_buf_write,   // Holding buffer written
  input  wire logic        tx_buf_move,    // Buffer moved to shifter
  input  wire logic        rx_char_done,   // Character in rx buffer
  input  wire logic        rx_buf_read,    // Receive buffer read
  input  wire logic        rx_overrun,     // Overrun event
  input  wire logic        rx_framing,     // Framing error event
  output logic             irq             // Interrupt request level
);

  ////////////////////////////////////////////////////////////////////////////

  logic [1:0]  enable_r,   enable_nxt;
  logic        tx_flag_r,  tx_flag_nxt;
  logic        rx_flag_r,  rx_flag_nxt;
  logic        ovr_r,      ovr_nxt;
  logic        fe_r,       fe_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic        ack_r,      ack_nxt;
  logic        irq_r,      irq_nxt;
  logic [15:0] vector;
  logic        wr_en,      wr_flags;
  logic        lane0;

  assign lane0    = byteenable[0];
  // A request is accepted on the cycle before the acknowledge pulse, while ack_r is low.
  assign wr_en    = write && !ack_r && lane0 &&
                    address == spi_irq_pkg::ADDR_IRQ_ENABLE;
  assign wr_flags = write && !ack_r && lane0 &&
                    address == spi_irq_pkg::ADDR_IRQ_FLAGS;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    if (rx_flag_r && enable_r[spi_irq_pkg::BIT_RX]) begin
      vector = spi_irq_pkg::VEC_RX;
    end else if (tx_flag_r && enable_r[spi_irq_pkg::BIT_TX]) begin
      vector = spi_irq_pkg::VEC_TX;
    end else begin
      vector = spi_irq_pkg::VEC_NONE;
    end
  end

  always_comb begin
    enable_nxt  = enable_r;
    tx_flag_nxt = tx_flag_r;
    rx_flag_nxt = rx_flag_r;
    ovr_nxt     = ovr_r;
    fe_nxt      = fe_r;
    if (wr_en) begin
      enable_nxt = writedata[1:0];
    end
    // Software clears a flag by writing a one; the hardware setting
    // event is applied afterwards so that it wins a same-cycle clear.
    if (wr_flags) begin
      if (writedata[spi_irq_pkg::BIT_TX]) begin
        tx_flag_nxt = 1'b0;
      end
      if (writedata[spi_irq_pkg::BIT_RX]) begin
        rx_flag_nxt = 1'b0;
      end
    end
    if (tx_buf_write) begin
      tx_flag_nxt = 1'b0;
    end
    if (tx_buf_move) begin
      tx_flag_nxt = 1'b1;
    end
    if (rx_buf_read) begin
      rx_flag_nxt = 1'b0;
      ovr_nxt     = 1'b0;
      fe_nxt      = 1'b0;
    end
    if (rx_char_done) begin
      rx_flag_nxt = 1'b1;
    end
    if (rx_overrun) begin
      ovr_nxt = 1'b1;
    end
    if (rx_framing) begin
      fe_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_r  <= spi_irq_pkg::ENABLE_RESET;
      tx_flag_r <= spi_irq_pkg::TX_FLAG_RESET;
      rx_flag_r <= spi_irq_pkg::RX_FLAG_RESET;
      ovr_r     <= 1'b0;
      fe_r      <= 1'b0;
    end else begin
      enable_r  <= enable_nxt;
      tx_flag_r <= tx_flag_nxt;
      rx_flag_r <= rx_flag_nxt;
      ovr_r     <= ovr_nxt;
      fe_r      <= fe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Every access takes two cycles; the extra cycle lets read data come
  // from a flip-flop, at the cost of bus throughput.
  always_comb begin
    ack_nxt      = (read || write) && !ack_r;
    readdata_nxt = readdata_r;
    irq_nxt      = (tx_flag_nxt && enable_nxt[spi_irq_pkg::BIT_TX]) ||
                   (rx_flag_nxt && enable_nxt[spi_irq_pkg::BIT_RX]);
    if (read && !ack_r) begin
      readdata_nxt = 32'h0000_0000;
      unique case (address)
        spi_irq_pkg::ADDR_IRQ_ENABLE: begin
          readdata_nxt[1:0] = enable_r;
        end
        spi_irq_pkg::ADDR_IRQ_FLAGS: begin
          readdata_nxt[spi_irq_pkg::BIT_TX] = tx_flag_r;
          readdata_nxt[spi_irq_pkg::BIT_RX] = rx_flag_r;
        end
        spi_irq_pkg::ADDR_IRQ_VECTOR: begin
          readdata_nxt[15:0] = vector;
        end
        spi_irq_pkg::ADDR_ERR_STATUS: begin
          readdata_nxt[spi_irq_pkg::BIT_OVERRUN] = ovr_r;
          readdata_nxt[spi_irq_pkg::BIT_FRAMING] = fe_r;
        end
        default: begin
          readdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0000_0000;
      irq_r      <= 1'b0;
    end else begin
      ack_r      <= ack_nxt;
      readdata_r <= readdata_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // Waitrequest is low only in the acknowledge cycle; ack_r is a flop
  // and its inverse is registered equivalently by construction.
  logic wait_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !ack_nxt;
    end
  end

  assign waitrequest = wait_r;
  assign readdata    = readdata_r;
  assign irq         = irq_r;

endmodule

//--- irq_props.sv
/* Checker on the ports of the interrupt flag block.
   Assumes one clock and the asynchronous low reset. */
`timescale 1ns/10ps
module irq_props (
  input wire logic        clk,          // Clock
  input wire logic        arst_n,       // Reset
  input wire logic [3:0]  address,      // Address
  input wire logic        read,         // Read
  input wire logic        write,        // Write
  input wire logic [31:0] readdata,     // Data
  input wire logic        waitrequest,  // Stall
  input wire logic        tx_buf_write, // Tx write
  input wire logic        tx_buf_move,  // Tx move
  input wire logic        rx_char_done, // Rx done
  input wire logic        rx_buf_read,  // Rx read
  input wire logic        irq           // Request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire quiet = !write && !tx_buf_move && !rx_char_done;
  sequence s_take; (read || write) && waitrequest; endsequence
  a_ack_one: assert property (s_take |=> !waitrequest)
    else $error("no acknowledge");
  a_ack_drop: assert property (!waitrequest |=> waitrequest)
    else $error("acknowledge too long");
  a_vec_code: assert property (s_take ##0 read && address == 4'h8 |=>
    readdata inside {32'h0, 32'h2, 32'h4}) else $error("bad vector");
  a_rd_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved");
  a_irq_rise: assert property ($rose(irq) |->
    $past(write || tx_buf_move || rx_char_done)) else $error("irq rose");
  a_irq_fall: assert property ($fell(irq) |->
    $past(write || tx_buf_write || rx_buf_read)) else $error("irq fell");
  a_tx_clear: assert property (tx_buf_write && quiet |=> !$rose(irq))
    else $error("write raised irq");
  a_rx_clear: assert property (rx_buf_read && quiet |=> !$rose(irq))
    else $error("read raised irq");
endmodule
bind spi_serial_irq_flags_vector irq_props u_props (.*);

//--- irq_sink.sv
/* Processor side model: latches a request until serviced.
   Assumes irq is a level on the same clock. */
`timescale 1ns/10ps
module irq_sink (
  input  wire logic clk,    // Clock
  input  wire logic arst_n, // Reset
  input  wire logic irq,    // Request
  input  wire logic ack,    // Serviced
  output logic      taken   // Request seen
);
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) taken <= 1'b0;
    else taken <= (taken | irq) & ~ack;
endmodule

//--- tb_top.sv
/* Bench: bus tasks, event pulses and expected register values.
   Assumes the package, checker and sink compile first. */
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  n_errors++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic        waitrequest, irq, taken;
  logic        ack = 1'b0;
  logic [5:0]  ev = 6'h0;
  int          n_errors = 0;
  int          total_checks = 0;
  always #25 clk = ~clk;
  spi_serial_irq_flags_vector dut (.clk(clk), .arst_n(arst_n),
    .address(address), .read(read), .write(write), .byteenable(4'hf),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .tx_buf_write(ev[0]), .tx_buf_move(ev[1]), .rx_char_done(ev[2]),
    .rx_buf_read(ev[3]), .rx_overrun(ev[4]), .rx_framing(ev[5]),
    .irq(irq));
  irq_sink u_sink (.clk(clk), .arst_n(arst_n), .irq(irq), .ack(ack),
    .taken(taken));
  ////////////////////////
  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    for (i = 0; i < 20 && waitrequest !== 1'b0; i++) @(posedge clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 6'h0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdc(4'h0, 32'h0);
    rdc(4'h4, 32'h2);
    rdc(4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'h2);
    rdc(4'h8, 32'h4);
    `CHK({irq, taken}, 2'h3)
    ack <= 1'b1;
    pulse(6'h01);
    rdc(4'h4, 32'h0);
    `CHK({irq, taken}, 2'h0)
    pulse(6'h02);
    rdc(4'h4, 32'h2);
    bus(1'b1, 4'h0, 32'h3);
    pulse(6'h14);
    rdc(4'h8, 32'h2);
    rdc(4'h4, 32'h3);
    pulse(6'h20);
    rdc(4'hc, 32'h60);
    pulse(6'h08);
    rdc(4'hc, 32'h0);
    rdc(4'h8, 32'h4);
    bus(1'b1, 4'h0, 32'h1);
    rdc(4'h8, 32'h0);
    `CHK(irq, 1'b0)
    pulse(6'h04);
    rdc(4'h8, 32'h2);
    bus(1'b1, 4'h4, 32'h3);
    rdc(4'h4, 32'h0);
    `CHK(irq, 1'b0)
    rdc(4'h2, 32'h0);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rdc(4'h4, 32'h2);
    rdc(4'h0, 32'h0);
    print_verdict();
  end
endmodule
